// *** bds_top.sv ***
// drive select remap, tape match, dma gating and drive id pins
// assumes host strobes and drive pins are synchronous to clk_sys_in
//
// Summary of operation
// [R1] boot map 01 or 10 makes host drive numbers virtual and remaps the swapped pair
// [R2] boot map 10 with drive number 00 drives physical drive 2 lines
// [R3] tape choice names a virtual drive; its select plus motor means tape mode
// [R4] tape choice 00 never gives tape mode, drive 0 is boot drive
// [R5] reset clears the drive control register to zero
// [R6] writing 0ch to drive control sets the dma gating bit
// [R7] gating bit plus dma ack and a strobe acts as internal chip select
// [R8] density output polarity is programmable to suit the drive type
// [R9] media type pins are sampled and readable in the tape and boot register
// [R10] drive type pins are sampled and readable in the tape and boot register
// [R11] tape mode is set only by software in the tape and boot register
// [R12] read window status output follows the data separator read gate
// [R13] drive number decodes one-hot; motor enables come straight from register
// [R14] boot map 00 identity, 01 swaps drives 0 and 1, 10 swaps 0 and 2
// [R15] boot map 11 acts as identity; drive 3 always passes straight through
`default_nettype none
module bds_top (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // register port
    input wire logic [bds_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [bds_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [bds_pkg::DATA_W-1:0] reg_rdata_out,
    // host bus chip select path
    input wire logic cs_n_in,
    input wire logic dma_ack_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    output logic internal_cs_out,
    output logic dma_gate_out,
    // drive interface
    output logic [3:0] physical_drive_select_pin_out,
    output logic [3:0] physical_motor_enable_pin_out,
    output logic tape_mode_out,
    input wire logic [1:0] density_rate_in,
    output logic density_select_out_0,
    output logic density_select_out_1,
    input wire logic [1:0] media_type_in,
    input wire logic [1:0] drive_type_in,
    input wire logic read_gate_in,
    output logic read_window_status_out
);
    import bds_pkg::*;

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] drive_control_reg_q;
    logic [1:0] tape_drive_choice_q;
    logic [1:0] boot_drive_map_q;
    logic [1:0] media_type_q;
    logic [1:0] drive_type_q;
    logic [1:0] density_pol_q;
    logic [DATA_W-1:0] rdata_q;
    logic [3:0] phys_sel_q;
    logic [3:0] phys_me_q;
    logic tape_mode_q;
    logic ics_q;
    logic rdwin_q;
    logic [1:0] den_q;

    logic wr_dcr;
    logic wr_tbr;
    logic wr_den;
    logic [3:0] virt_sel;
    logic [1:0] tape_phys;
    logic ics_d;
    logic tape_mode_d;
    logic [DATA_W-1:0] rdata_d;

    bds_map_if map_if ();

    // ---------------------------------------------------------------
    // write decode
    // ---------------------------------------------------------------
    // unmapped offsets are ignored on write
    assign wr_dcr = reg_wr_in && (reg_addr_in == OFS_DRIVE_CTRL);
    assign wr_tbr = reg_wr_in && (reg_addr_in == OFS_TAPE_BOOT);
    assign wr_den = reg_wr_in && (reg_addr_in == OFS_DENSITY);

    // drive control register: cleared by reset, any byte accepted,
    // so the usual 0ch start-up write lands the gating bit
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            drive_control_reg_q <= DCR_RESET; // [R5]
        end else if (wr_dcr) begin
            drive_control_reg_q <= reg_wdata_in; // [R6]
        end
    end

    // tape and boot fields; the only way into tape mode is this write,
    // there is deliberately no strap input for it
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            tape_drive_choice_q <= TBR_RW_RESET[1:0];
            boot_drive_map_q <= TBR_RW_RESET[3:2];
        end else if (wr_tbr) begin
            tape_drive_choice_q <= reg_wdata_in[TBR_TAPE_LSB +: 2]; // [R11]
            boot_drive_map_q <= reg_wdata_in[TBR_BOOT_LSB +: 2]; // [R1]
        end
    end

    // density polarity, set by the drive specification path
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            density_pol_q <= DEN_POL_RESET;
        end else if (wr_den) begin
            density_pol_q <= reg_wdata_in[DEN_POL_LSB +: 2]; // [R8]
        end
    end

    // ---------------------------------------------------------------
    // drive id sampling
    // ---------------------------------------------------------------
    // sampled every cycle so a read shows the value of one cycle ago;
    // drives that change id mid-read give the older value
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            media_type_q <= 2'h0;
            drive_type_q <= 2'h0;
        end else begin
            media_type_q <= media_type_in; // [R9]
            drive_type_q <= drive_type_in; // [R10]
        end
    end

    // ---------------------------------------------------------------
    // virtual drive lines and remap
    // ---------------------------------------------------------------
    // one-hot decode of the host drive number
    always_comb begin
        virt_sel = 4'h0;
        virt_sel[drive_control_reg_q[DCR_DRV_LSB +: 2]] = 1'b1; // [R13]
    end

    assign map_if.boot_drive_map = boot_drive_map_q;
    assign map_if.virtual_drive_select = virt_sel;
    assign map_if.virtual_motor_enable =
        drive_control_reg_q[DCR_MOTOR_LSB +: 4]; // [R13]

    bds_remap u_remap (
        .map_if(map_if)
    );

    // pins are registered so a map change never glitches a select line;
    // costs one cycle of latency after a register write
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            phys_sel_q <= 4'h0;
            phys_me_q <= 4'h0;
        end else begin
            phys_sel_q <= map_if.mapped_select; // [R1] [R2]
            phys_me_q <= map_if.mapped_motor; // [R1] [R2]
        end
    end

    // ---------------------------------------------------------------
    // tape match
    // ---------------------------------------------------------------
    // the choice field is a virtual number; it is carried through the
    // boot map and compared against the mapped physical lines
    assign tape_phys = bds_partner(boot_drive_map_q, tape_drive_choice_q); // [R3]

    always_comb begin
        tape_mode_d = 1'b0;
        if (tape_drive_choice_q != TAPE_NONE) begin // [R4]
            tape_mode_d = map_if.mapped_select[tape_phys] &&
                map_if.mapped_motor[tape_phys]; // [R3]
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            tape_mode_q <= 1'b0;
        end else begin
            tape_mode_q <= tape_mode_d; // [R3] [R11]
        end
    end

    // ---------------------------------------------------------------
    // dma gating
    // ---------------------------------------------------------------
    // with the gate set an acknowledged dma strobe selects the chip
    // even when the external select is high; a second controller on
    // the same bus will then contend, so software must clear the gate
    always_comb begin
        ics_d = !cs_n_in;
        if (drive_control_reg_q[DCR_GATE_BIT] && !dma_ack_n_in &&
                (!rd_n_in || !wr_n_in)) begin
            ics_d = 1'b1; // [R7]
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            ics_q <= 1'b0;
        end else begin
            ics_q <= ics_d; // [R7]
        end
    end

    // ---------------------------------------------------------------
    // density and read window outputs
    // ---------------------------------------------------------------
    // rate bits flipped per pin by the programmed polarity
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            den_q <= 2'h0;
        end else begin
            den_q <= density_rate_in ^ density_pol_q; // [R8]
        end
    end

    // read gate mirrored out for phase-lock loop diagnostics
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            rdwin_q <= 1'b0;
        end else begin
            rdwin_q <= read_gate_in; // [R12]
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    // unmapped offsets read as zero; data stand one cycle only
    always_comb begin
        rdata_d = '0;
        case (reg_addr_in)
            OFS_DRIVE_CTRL: begin
                rdata_d = drive_control_reg_q;
            end
            OFS_TAPE_BOOT: begin
                rdata_d[TBR_TAPE_LSB +: 2] = tape_drive_choice_q;
                rdata_d[TBR_BOOT_LSB +: 2] = boot_drive_map_q;
                rdata_d[TBR_MEDIA_LSB +: 2] = media_type_q; // [R9]
                rdata_d[TBR_DTYPE_LSB +: 2] = drive_type_q; // [R10]
            end
            OFS_DENSITY: begin
                rdata_d[DEN_POL_LSB +: 2] = density_pol_q;
            end
            OFS_STATUS: begin
                rdata_d[STAT_RDWIN_BIT] = rdwin_q; // [R12]
                rdata_d[STAT_TAPE_BIT] = tape_mode_q;
                rdata_d[STAT_ICS_BIT] = ics_q;
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            rdata_q <= '0;
        end else if (reg_rd_in) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ---------------------------------------------------------------
    assign reg_rdata_out = rdata_q;
    assign internal_cs_out = ics_q;
    assign dma_gate_out = drive_control_reg_q[DCR_GATE_BIT];
    assign physical_drive_select_pin_out = phys_sel_q;
    assign physical_motor_enable_pin_out = phys_me_q;
    assign tape_mode_out = tape_mode_q;
    assign density_select_out_0 = den_q[0];
    assign density_select_out_1 = den_q[1];
    assign read_window_status_out = rdwin_q;
endmodule
`default_nettype wire

// *** bds_pkg.sv ***
// constants and helpers for the boot drive select remap block
// assumes one 50 MHz clock and a synchronous active-high reset
`default_nettype none
package bds_pkg;
    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_DRIVE_CTRL = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_TAPE_BOOT = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_DENSITY = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h5;
    // ---------------------------------------------------------------
    // drive control fields
    // ---------------------------------------------------------------
    localparam int DCR_DRV_LSB = 0;
    localparam int DCR_RUN_BIT = 2;
    localparam int DCR_GATE_BIT = 3;
    localparam int DCR_MOTOR_LSB = 4;
    localparam logic [DATA_W-1:0] DCR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DCR_POST_VALUE = 8'h0c;
    // ---------------------------------------------------------------
    // tape and boot fields
    // ---------------------------------------------------------------
    localparam int TBR_TAPE_LSB = 0;
    localparam int TBR_BOOT_LSB = 2;
    localparam int TBR_MEDIA_LSB = 4;
    localparam int TBR_DTYPE_LSB = 6;
    localparam logic [3:0] TBR_RW_RESET = 4'h0;
    // density polarity and status fields
    localparam int DEN_POL_LSB = 0;
    localparam logic [1:0] DEN_POL_RESET = 2'h0;
    localparam int STAT_RDWIN_BIT = 0;
    localparam int STAT_TAPE_BIT = 1;
    localparam int STAT_ICS_BIT = 2;
    // ---------------------------------------------------------------
    // boot map codes
    // ---------------------------------------------------------------
    localparam logic [1:0] MAP_IDENT = 2'b00;
    localparam logic [1:0] MAP_SWAP01 = 2'b01;
    localparam logic [1:0] MAP_SWAP02 = 2'b10;
    localparam logic [1:0] TAPE_NONE = 2'b00;
    localparam int NUM_DRIVES = 4;

    // partner drive number of drive d under boot map m; each map is a
    // pure swap, so the same function serves both directions
    function automatic logic [1:0] bds_partner(input logic [1:0] m,
                                               input logic [1:0] d);
        logic [1:0] r;
        r = d;
        case (m)
            MAP_SWAP01: begin
                if (d == 2'd0) r = 2'd1;
                else if (d == 2'd1) r = 2'd0;
            end
            MAP_SWAP02: begin
                if (d == 2'd0) r = 2'd2;
                else if (d == 2'd2) r = 2'd0;
            end
            default: r = d;
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

// *** bds_map_if.sv ***
// carrier between the drive control logic and the select remapper
// assumes both ends sit in the same clock domain
`default_nettype none
interface bds_map_if;
    logic [1:0] boot_drive_map;
    logic [3:0] virtual_drive_select;
    logic [3:0] virtual_motor_enable;
    logic [3:0] mapped_select;
    logic [3:0] mapped_motor;
    modport src (
        output boot_drive_map,
        output virtual_drive_select,
        output virtual_motor_enable,
        input mapped_select,
        input mapped_motor
    );
    modport remap (
        input boot_drive_map,
        input virtual_drive_select,
        input virtual_motor_enable,
        output mapped_select,
        output mapped_motor
    );
endinterface
`default_nettype wire

// *** bds_remap.sv ***
// combinational virtual-to-physical drive line remapper
// assumes the caller registers the results before they reach pins
`default_nettype none
module bds_remap (
    bds_map_if.remap map_if
);
    import bds_pkg::*;

    // ---------------------------------------------------------------
    // per-pin selection
    // ---------------------------------------------------------------
    // each physical pin takes the virtual line of its swap partner;
    // reserved code 11 falls to identity inside the partner function
    always_comb begin
        for (int p = 0; p < NUM_DRIVES; p++) begin
            map_if.mapped_select[p] = map_if.virtual_drive_select[
                bds_partner(map_if.boot_drive_map, 2'(p))]; // [R1] [R2] [R14] [R15]
            map_if.mapped_motor[p] = map_if.virtual_motor_enable[
                bds_partner(map_if.boot_drive_map, 2'(p))]; // [R1] [R14] [R15]
        end
    end
endmodule
`default_nettype wire

// *** bds_checker.sv ***
// assertions bound onto the drive select remap top
// assumes one clock domain and the register offsets of bds_pkg
`default_nettype none
module bds_checker (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic cs_n_in,
    input wire logic dma_ack_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic internal_cs_out,
    input wire logic dma_gate_out,
    input wire logic [3:0] physical_drive_select_pin_out,
    input wire logic [3:0] physical_motor_enable_pin_out,
    input wire logic tape_mode_out,
    input wire logic read_gate_in,
    input wire logic read_window_status_out
);
    import bds_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] dcr_q;
    logic [3:0] tbr_q;
    logic [3:0] sel_x;
    logic [3:0] mot_x;
    logic tape_x;
    logic ics_x;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    // physical pin of virtual drive d under boot map m
    function automatic logic [1:0] phys(input logic [1:0] m, input logic [1:0] d);
        if (m == 2'b01 && !d[1]) return d ^ 2'b01;
        if (m == 2'b10 && !d[0]) return d ^ 2'b10;
        return d;
    endfunction
    // shadow of the software fields, updated on the device's own write edge
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            dcr_q <= 8'h00;
            tbr_q <= 4'h0;
        end else if (reg_wr_in && reg_addr_in == OFS_DRIVE_CTRL) begin
            dcr_q <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == OFS_TAPE_BOOT) begin
            tbr_q <= reg_wdata_in[3:0];
        end
    end
    // expected pins, one edge ahead of the pin flops
    always_comb begin
        sel_x = 4'h0;
        mot_x = 4'h0;
        sel_x[phys(tbr_q[3:2], dcr_q[1:0])] = 1'b1;
        for (int v = 0; v < 4; v++) begin
            mot_x[phys(tbr_q[3:2], 2'(v))] = dcr_q[4+v];
        end
        tape_x = tbr_q[1:0] != TAPE_NONE && sel_x[phys(tbr_q[3:2], tbr_q[1:0])]
            && mot_x[phys(tbr_q[3:2], tbr_q[1:0])];
    end
    assign ics_x = !cs_n_in || (dma_gate_out && !dma_ack_n_in && !(rd_n_in && wr_n_in));
    property p_map;
        !$past(srst_in) |-> physical_drive_select_pin_out == $past(sel_x);
    endproperty
    a_map: assert property (p_map) else $error("select pins off map");
    property p_motor;
        !$past(srst_in) |-> physical_motor_enable_pin_out == $past(mot_x);
    endproperty
    a_motor: assert property (p_motor) else $error("motor pins off map");
    property p_tape;
        !$past(srst_in) |-> tape_mode_out == $past(tape_x);
    endproperty
    a_tape: assert property (p_tape) else $error("tape mode wrong");
    property p_gate;
        reg_wr_in && reg_addr_in == OFS_DRIVE_CTRL |=> dma_gate_out == $past(reg_wdata_in[3]);
    endproperty
    a_gate: assert property (p_gate) else $error("gate bit not taken");
    property p_ics;
        !$past(srst_in) |-> internal_cs_out == $past(ics_x);
    endproperty
    a_ics: assert property (p_ics) else $error("internal select wrong");
    property p_rdwin;
        !$past(srst_in) |-> read_window_status_out == $past(read_gate_in);
    endproperty
    a_rdwin: assert property (p_rdwin) else $error("read window lags wrong");
    property p_reset;
        $fell(srst_in) |-> !dma_gate_out && !tape_mode_out && physical_motor_enable_pin_out == 4'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs set after reset");
    property p_rdback;
        reg_rd_in && reg_addr_in == OFS_DRIVE_CTRL |=> reg_rdata_out == dcr_q;
    endproperty
    a_rdback: assert property (p_rdback) else $error("drive control readback");
endmodule
bind bds_top bds_checker i_chk (.clk_sys_in, .srst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cs_n_in, .dma_ack_n_in, .rd_n_in, .wr_n_in,
    .internal_cs_out, .dma_gate_out, .physical_drive_select_pin_out,
    .physical_motor_enable_pin_out, .tape_mode_out, .read_gate_in, .read_window_status_out);
`default_nettype wire

// *** bds_drive_model.sv ***
// behavioural drive set: id pins of the selected drive and a read gate
// assumes active-high selects from the block
`default_nettype none
module bds_drive_model (
    input wire logic clk_sys_in,
    input wire logic [3:0] sel_in,
    output logic [1:0] media_type_out,
    output logic [1:0] drive_type_out,
    output logic read_gate_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q = 4'h0;
    // gate pattern changes often so a stuck status shows
    always_ff @(posedge clk_sys_in) begin
        cnt_q <= cnt_q + 4'h1;
    end
    assign read_gate_out = cnt_q[2] ^ cnt_q[0];
    // drive p reports media p and type 3-p
    always_comb begin
        media_type_out = 2'b00;
        drive_type_out = 2'b00;
        for (int p = 0; p < 4; p++) begin
            if (sel_in[p]) begin
                media_type_out = 2'(p);
                drive_type_out = 2'(3 - p);
            end
        end
    end
endmodule
`default_nettype wire

// *** boot_drive_select_remap_tb.sv ***
// self-checking bench for the drive select remap block
// assumes bds_pkg, bds_top, the checker and the drive model are compiled first
`default_nettype none
module boot_drive_select_remap_tb;
    import bds_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in, srst_in, reg_wr_in, reg_rd_in, cs_n_in, dma_ack_n_in, rd_n_in, wr_n_in;
    logic [2:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out;
    logic internal_cs_out, dma_gate_out, tape_mode_out, density_select_out_0;
    logic density_select_out_1, read_gate_in, read_window_status_out;
    logic [3:0] physical_drive_select_pin_out, physical_motor_enable_pin_out;
    logic [1:0] density_rate_in, media_type_in, drive_type_in;
    logic [31:0] seed = 32'h00014c26;
    int errors = 0;
    int checks = 0;
    bds_top i_dut (.clk_sys_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .cs_n_in, .dma_ack_n_in, .rd_n_in, .wr_n_in,
        .internal_cs_out, .dma_gate_out, .physical_drive_select_pin_out,
        .physical_motor_enable_pin_out, .tape_mode_out, .density_rate_in,
        .density_select_out_0, .density_select_out_1, .media_type_in, .drive_type_in,
        .read_gate_in, .read_window_status_out);
    bds_drive_model i_drv (.clk_sys_in, .sel_in(physical_drive_select_pin_out),
        .media_type_out(media_type_in), .drive_type_out(drive_type_in),
        .read_gate_out(read_gate_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int phys(int m, int d);
        if (m == 1 && d < 2) return d ^ 1;
        if (m == 2 && d % 2 == 0) return d ^ 2;
        return d;
    endfunction
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // bus write: one strobe cycle, released after the taking edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_sys_in);
        check(reg_rdata_out, e);
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // watchdog: the whole run needs under a thousand cycles
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        int dcr_m, tbr_m, p, mx;
        {srst_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = {1'b1, 13'h0};
        {cs_n_in, dma_ack_n_in, rd_n_in, wr_n_in, density_rate_in} = 6'h3c;
        repeat (3) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        rc(OFS_DRIVE_CTRL, DCR_RESET);
        check(physical_motor_enable_pin_out, 8'h00);
        rc(3'h6, 8'h00);
        wr(OFS_DRIVE_CTRL, DCR_POST_VALUE);
        @(negedge clk_sys_in);
        check(dma_gate_out, 8'h01);
        // host strobe table with the gate set, then clear
        for (int g = 1; g >= 0; g--) begin
            wr(OFS_DRIVE_CTRL, g ? 8'h0c : 8'h00);
            for (int i = 0; i < 16; i++) begin
                @(posedge clk_sys_in);
                {cs_n_in, dma_ack_n_in, rd_n_in, wr_n_in} <= 4'(i);
                @(posedge clk_sys_in);
                @(negedge clk_sys_in);
                check(internal_cs_out, !i[3] || (g && !i[2] && !(i[1] && i[0])));
            end
        end
        // every boot map, drive number and tape choice with random motors
        for (int m = 0; m < 4; m++) begin
            for (int d = 0; d < 4; d++) begin
                for (int t = 0; t < 4; t++) begin
                    seed = lfsr(seed);
                    dcr_m = {seed[3:0], 2'b00, 2'(d)};
                    tbr_m = m * 4 + t;
                    wr(OFS_TAPE_BOOT, 8'(tbr_m));
                    wr(OFS_DRIVE_CTRL, 8'(dcr_m));
                    repeat (2) @(posedge clk_sys_in);
                    @(negedge clk_sys_in);
                    p = phys(m, d);
                    mx = 0;
                    for (int v = 0; v < 4; v++) begin
                        if (dcr_m[4+v]) mx |= 1 << phys(m, v);
                    end
                    check(physical_drive_select_pin_out, 8'(1 << p));
                    check(physical_motor_enable_pin_out, 8'(mx));
                    check(tape_mode_out, t != 0 && d == t && dcr_m[4+t]);
                    rc(OFS_TAPE_BOOT, 8'((3 - p) * 64 + p * 16 + tbr_m));
                end
            end
        end
        // density polarity against every rate code
        for (int k = 0; k < 16; k++) begin
            wr(OFS_DENSITY, 8'(k % 4));
            density_rate_in <= 2'(k / 4);
            repeat (2) @(posedge clk_sys_in);
            @(negedge clk_sys_in);
            check({density_select_out_1, density_select_out_0}, 8'((k % 4) ^ (k / 4)));
        end
        // second reset in mid-run
        @(posedge clk_sys_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        rc(OFS_DENSITY, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
